// ==== verilog/dgp_pkg.sv ====
// Package of register offsets, reset values and field positions for the dual GPIO ports
package dgp_pkg;
	localparam int unsigned DATA_W = 8;
	// Printed offsets are not all multiples of four: these are word indexes
	localparam logic [7:0] IDX_PORT_H_DIRECTION = 8'h10;
	localparam logic [7:0] IDX_PORT_H_PINS_LATCH = 8'h11;
	localparam logic [7:0] IDX_PORT_J_DIRECTION = 8'h12;
	localparam logic [7:0] IDX_PORT_J_PINS_LATCH = 8'h13;
	localparam logic [7:0] IDX_ANALOG_CONVERTER_CONFIG_ONE = 8'h15;
	// Read-modify-write command registers, one per port
	localparam logic [7:0] IDX_PORT_H_BIT_OP = 8'h18;
	localparam logic [7:0] IDX_PORT_J_BIT_OP = 8'h19;
	localparam int unsigned ADDR_W = 10;
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_ADC_CFG = 8'h00;
	// Unimplemented bit 4 of the converter config reads as zero
	localparam logic [7:0] ADC_CFG_MASK = 8'hef;
	localparam int unsigned ANA_CFG_LSB = 0;
	localparam int unsigned ANA_CFG_W = 4;
	// Field values at or above this make the upper port H pins digital
	localparam logic [3:0] ANA_CFG_DIGITAL_MIN = 4'he;
	// Bit-op command layout: [2:0] bit index, [4:3] operation
	localparam int unsigned OP_BIT_LSB = 0;
	localparam int unsigned OP_CODE_LSB = 3;
	localparam logic [1:0] OP_CLEAR = 2'h0;
	localparam logic [1:0] OP_SET = 2'h1;
	localparam logic [1:0] OP_TOGGLE = 2'h2;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ==== verilog/dgp_pin_sync.sv ====
// Three-flop pin synchroniser with agreement filter for one port
`timescale 1ns/100ps
`default_nettype none
module dgp_pin_sync #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A level counts only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					level_o[g] <= 1'b0;
				end else if (s2_r[g] == s3_r[g]) begin
					level_o[g] <= s3_r[g];
				end
			end
		end
	endgenerate
endmodule // dgp_pin_sync
`default_nettype wire

// ==== verilog/dgp_port.sv ====
// One 8-bit port: direction register, output latch and pin drivers
`timescale 1ns/100ps
`default_nettype none
module dgp_port #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic dir_we_i,
	input wire logic lat_we_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [WIDTH-1:0] digital_en_i,
	output logic [WIDTH-1:0] dir_o,
	output logic [WIDTH-1:0] lat_o,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_n_o
);
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dir_o <= dgp_pkg::RST_DIRECTION;
		end else if (dir_we_i) begin
			dir_o <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			lat_o <= dgp_pkg::RST_LATCH;
		end else if (lat_we_i) begin
			lat_o <= wdata_i;
		end
	end

	// Driver follows the registers a cycle later so the pin itself is flop-driven
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_o <= '0;
			pin_oe_n_o <= '1;
		end else begin
			pin_o <= lat_o;
			pin_oe_n_o <= ~(~dir_o & digital_en_i);
		end
	end
endmodule // dgp_port
`default_nettype wire

// ==== verilog/dgp_top.sv ====
// Dual 8-bit GPIO ports H and J with AXI4-Lite register access
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module dgp_top #(
	parameter int unsigned WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [dgp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dgp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [WIDTH-1:0] port_h_pins_i,
	output logic [WIDTH-1:0] port_h_pins_o,
	output logic [WIDTH-1:0] port_h_pins_oe_n_o,
	input wire logic [WIDTH-1:0] port_j_pins_i,
	output logic [WIDTH-1:0] port_j_pins_o,
	output logic [WIDTH-1:0] port_j_pins_oe_n_o,
	output logic [3:0] port_h_upper_pins_analog_o
);
	logic [WIDTH-1:0] h_lvl, j_lvl, h_dir, j_dir, h_lat, j_lat;
	logic [7:0] adc_cfg_r;
	logic [dgp_pkg::ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic aw_have_r, w_have_r;
	logic do_write;
	logic [7:0] w_idx;
	logic w_ok;
	logic [WIDTH-1:0] rmw_val;
	logic [WIDTH-1:0] h_digital;
	logic h_upper_digital;
	logic h_dir_we, h_lat_we, j_dir_we, j_lat_we;
	logic [7:0] rd_byte;
	logic rd_ok;
	logic [7:0] r_idx;

	// Port reads see the synchronised pin levels sampled before the access
	dgp_pin_sync #(.WIDTH(WIDTH)) u_sync_h (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_i(port_h_pins_i),
		.level_o(h_lvl)
	);
	dgp_pin_sync #(.WIDTH(WIDTH)) u_sync_j (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_i(port_j_pins_i),
		.level_o(j_lvl)
	);

	assign h_upper_digital = adc_cfg_r[dgp_pkg::ANA_CFG_LSB +: dgp_pkg::ANA_CFG_W] >= dgp_pkg::ANA_CFG_DIGITAL_MIN;
	// Lower nibble is always digital; upper nibble only when the converter releases it
	assign h_digital = {{4{h_upper_digital}}, 4'hf};

	// Write channel: address and data accepted in either order
	assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	assign w_idx = aw_addr_r[9:2];
	assign w_ok = (aw_addr_r[1:0] == 2'h0) && (w_idx == dgp_pkg::IDX_PORT_H_DIRECTION ||
		w_idx == dgp_pkg::IDX_PORT_H_PINS_LATCH || w_idx == dgp_pkg::IDX_PORT_J_DIRECTION ||
		w_idx == dgp_pkg::IDX_PORT_J_PINS_LATCH || w_idx == dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE ||
		w_idx == dgp_pkg::IDX_PORT_H_BIT_OP || w_idx == dgp_pkg::IDX_PORT_J_BIT_OP);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dgp_pkg::AXI_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= w_ok ? dgp_pkg::AXI_OKAY : dgp_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Bit operation on the pin image: operand is pins, result goes to the latch
	always_comb begin
		logic [WIDTH-1:0] src;
		logic [WIDTH-1:0] msk;
		src = (w_idx == dgp_pkg::IDX_PORT_H_BIT_OP) ? h_lvl : j_lvl;
		msk = '0;
		msk[w_data_r[dgp_pkg::OP_BIT_LSB +: 3]] = 1'b1;
		unique case (w_data_r[dgp_pkg::OP_CODE_LSB +: 2])
			dgp_pkg::OP_CLEAR: rmw_val = src & ~msk;
			dgp_pkg::OP_SET: rmw_val = src | msk;
			dgp_pkg::OP_TOGGLE: rmw_val = src ^ msk;
			default: rmw_val = src;
		endcase
	end

	// Byte lane 0 carries every register
	assign h_dir_we = do_write && w_strb_r[0] && w_idx == dgp_pkg::IDX_PORT_H_DIRECTION;
	assign j_dir_we = do_write && w_strb_r[0] && w_idx == dgp_pkg::IDX_PORT_J_DIRECTION;
	assign h_lat_we = do_write && w_strb_r[0] && (w_idx == dgp_pkg::IDX_PORT_H_PINS_LATCH ||
		w_idx == dgp_pkg::IDX_PORT_H_BIT_OP);
	assign j_lat_we = do_write && w_strb_r[0] && (w_idx == dgp_pkg::IDX_PORT_J_PINS_LATCH ||
		w_idx == dgp_pkg::IDX_PORT_J_BIT_OP);

	// Latches load at the end of the write cycle, all eight bits at once
	dgp_port #(.WIDTH(WIDTH)) u_port_h (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.dir_we_i(h_dir_we),
		.lat_we_i(h_lat_we),
		.wdata_i((w_idx == dgp_pkg::IDX_PORT_H_BIT_OP) ? rmw_val : w_data_r[7:0]),
		.digital_en_i(h_digital),
		.dir_o(h_dir),
		.lat_o(h_lat),
		.pin_o(port_h_pins_o),
		.pin_oe_n_o(port_h_pins_oe_n_o)
	);
	// Port J has no alternate function: every pin is always digital
	dgp_port #(.WIDTH(WIDTH)) u_port_j (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.dir_we_i(j_dir_we),
		.lat_we_i(j_lat_we),
		.wdata_i((w_idx == dgp_pkg::IDX_PORT_J_BIT_OP) ? rmw_val : w_data_r[7:0]),
		.digital_en_i({WIDTH{1'b1}}),
		.dir_o(j_dir),
		.lat_o(j_lat),
		.pin_o(port_j_pins_o),
		.pin_oe_n_o(port_j_pins_oe_n_o)
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			adc_cfg_r <= dgp_pkg::RST_ADC_CFG;
		end else if (do_write && w_strb_r[0] && w_idx == dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE) begin
			adc_cfg_r <= w_data_r[7:0] & dgp_pkg::ADC_CFG_MASK;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			port_h_upper_pins_analog_o <= 4'hf;
		end else begin
			port_h_upper_pins_analog_o <= {4{~h_upper_digital}};
		end
	end

	// Read channel
	assign r_idx = s_axi_araddr[9:2];
	always_comb begin
		rd_ok = s_axi_araddr[1:0] == 2'h0;
		rd_byte = 8'h00;
		unique case (r_idx)
			dgp_pkg::IDX_PORT_H_DIRECTION: rd_byte = h_dir;
			dgp_pkg::IDX_PORT_H_PINS_LATCH: rd_byte = h_lvl;
			dgp_pkg::IDX_PORT_J_DIRECTION: rd_byte = j_dir;
			dgp_pkg::IDX_PORT_J_PINS_LATCH: rd_byte = j_lvl;
			dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE: rd_byte = adc_cfg_r;
			dgp_pkg::IDX_PORT_H_BIT_OP: rd_byte = h_lat;
			dgp_pkg::IDX_PORT_J_BIT_OP: rd_byte = j_lat;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= dgp_pkg::AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_ok ? dgp_pkg::AXI_OKAY : dgp_pkg::AXI_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	property p_dir_reset;
		@(posedge ref_clk_i) $fell(rst_i) |-> h_dir == 8'hff && j_dir == 8'hff;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction not all ones after reset");

	property p_input_off;
		@(posedge ref_clk_i) disable iff (rst_i) j_dir[0] |=> port_j_pins_oe_n_o[0];
	endproperty
	a_input_off: assert property (p_input_off) else $error("input pin driven");

	property p_output_drives;
		@(posedge ref_clk_i) disable iff (rst_i) !j_dir[0] |=> !port_j_pins_oe_n_o[0] && port_j_pins_o[0] == $past(j_lat[0]);
	endproperty
	a_output_drives: assert property (p_output_drives) else $error("output pin not driving latch");

	property p_h_output;
		@(posedge ref_clk_i) disable iff (rst_i) !h_dir[1] |=> !port_h_pins_oe_n_o[1];
	endproperty
	a_h_output: assert property (p_h_output) else $error("port h low output not driven");

	property p_analog_blocks;
		@(posedge ref_clk_i) disable iff (rst_i) !h_upper_digital |=> port_h_pins_oe_n_o[7:4] == 4'hf;
	endproperty
	a_analog_blocks: assert property (p_analog_blocks) else $error("analog pin driven");

	property p_read_pins;
		@(posedge ref_clk_i) disable iff (rst_i)
			s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h04c |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(j_lvl);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("port j read not pin level");

	property p_write_latch;
		@(posedge ref_clk_i) disable iff (rst_i) j_lat_we && w_idx == dgp_pkg::IDX_PORT_J_PINS_LATCH |=> j_lat == $past(w_data_r[7:0]);
	endproperty
	a_write_latch: assert property (p_write_latch) else $error("latch write lost");

	property p_rmw_set;
		@(posedge ref_clk_i) disable iff (rst_i)
			j_lat_we && w_idx == dgp_pkg::IDX_PORT_J_BIT_OP && w_data_r[4:3] == 2'h1
			|=> j_lat == ($past(j_lvl) | (8'h01 << $past(w_data_r[2:0])));
	endproperty
	a_rmw_set: assert property (p_rmw_set) else $error("bit set not based on pins");

	property p_bresp;
		@(posedge ref_clk_i) disable iff (rst_i) do_write |=> s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("no write response");

	property p_rmw_clear;
		@(posedge ref_clk_i) disable iff (rst_i)
			j_lat_we && w_idx == dgp_pkg::IDX_PORT_J_BIT_OP && w_data_r[4:3] == dgp_pkg::OP_CLEAR
			|=> j_lat == ($past(j_lvl) & ~(8'h01 << $past(w_data_r[2:0])));
	endproperty
	a_rmw_clear: assert property (p_rmw_clear) else $error("bit clear not based on pins");

	// The no-op code still rewrites the whole latch, so input pins overwrite their latch bits
	property p_rmw_none;
		@(posedge ref_clk_i) disable iff (rst_i)
			j_lat_we && w_idx == dgp_pkg::IDX_PORT_J_BIT_OP && w_data_r[4:3] == 2'h3 |=> j_lat == $past(j_lvl);
	endproperty
	a_rmw_none: assert property (p_rmw_none) else $error("pin levels not written to latch");

	property p_read_h_pins;
		@(posedge ref_clk_i) disable iff (rst_i)
			s_axi_arvalid && s_axi_arready && s_axi_araddr == {dgp_pkg::IDX_PORT_H_PINS_LATCH, 2'h0}
			|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(h_lvl);
	endproperty
	a_read_h_pins: assert property (p_read_h_pins) else $error("port h read not pin level");

	property p_analog_reset;
		@(posedge ref_clk_i) $fell(rst_i) |-> port_h_upper_pins_analog_o == 4'hf && adc_cfg_r == dgp_pkg::RST_ADC_CFG;
	endproperty
	a_analog_reset: assert property (p_analog_reset) else $error("upper port h pins not analog after reset");

	// Lane zero off: the write is answered but must leave every latch alone
	property p_strb_hold;
		@(posedge ref_clk_i) disable iff (rst_i) do_write && !w_strb_r[0] |=> $stable(h_lat) && $stable(j_lat);
	endproperty
	a_strb_hold: assert property (p_strb_hold) else $error("latch changed without lane zero");

	c_write: cover property (@(posedge ref_clk_i) j_lat_we);
	c_rmw: cover property (@(posedge ref_clk_i) h_lat_we && w_idx == dgp_pkg::IDX_PORT_H_BIT_OP);
	c_digital: cover property (@(posedge ref_clk_i) h_upper_digital);
	c_slverr: cover property (@(posedge ref_clk_i) s_axi_bvalid && s_axi_bresp == dgp_pkg::AXI_SLVERR);
endmodule // dgp_top
`default_nettype wire

// ==== verif/dgp_ext_pins.sv ====
// Model of the outside circuitry that drives the port pins
`timescale 1ns/100ps
`default_nettype none
module dgp_ext_pins (
	input wire logic [7:0] pins_o_i,
	input wire logic [7:0] oe_n_i,
	input wire logic [7:0] drive_i,
	output logic [7:0] level_o
);
	// Backs off wherever the device drives, so a driven pin shows the device's level
	assign level_o = (oe_n_i & drive_i) | (~oe_n_i & pins_o_i);
endmodule // dgp_ext_pins
`default_nettype wire

// ==== verif/dgp_top_tb.sv ====
// Register-level testbench for the dual GPIO ports
`timescale 1ns/100ps
`default_nettype none
module dgp_top_tb;
	logic ref_clk_i;
	logic rst_i;
	logic [9:0] awaddr;
	logic [9:0] araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rdv;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [1:0] rsp;
	logic [7:0] h_o, h_oe, h_in, j_o, j_oe, j_in, h_ext, j_ext;
	logic [3:0] ana;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	logic [1:0] opc [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
	logic [2:0] opb [4] = '{3'h7, 3'h5, 3'h0, 3'h0};
	logic [7:0] ope [4] = '{8'hb5, 8'h95, 8'h94, 8'h95};
	logic [7:0] cfg [3] = '{8'h0d, 8'h0e, 8'hff};
	logic [7:0] cfr [3] = '{8'h0d, 8'h0e, 8'hef};
	logic [3:0] cfa [3] = '{4'hf, 4'h0, 4'h0};
	logic [7:0] cfo [3] = '{8'hf0, 8'h00, 8'h00};

	dgp_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_h_pins_i(h_in),
		.port_h_pins_o(h_o), .port_h_pins_oe_n_o(h_oe), .port_j_pins_i(j_in), .port_j_pins_o(j_o),
		.port_j_pins_oe_n_o(j_oe), .port_h_upper_pins_analog_o(ana));
	dgp_ext_pins u_ext_h (.pins_o_i(h_o), .oe_n_i(h_oe), .drive_i(h_ext), .level_o(h_in));
	dgp_ext_pins u_ext_j (.pins_o_i(j_o), .oe_n_i(j_oe), .drive_i(j_ext), .level_o(j_in));

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [9:0] ba(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic close_out;
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		chk(n, {24'h0, e}, {24'h0, s});
	endtask

	// Handshakes are sampled at the falling edge, where registered outputs are settled
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic ah, wh, bh;
		bit done;
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 0;
		while (!done) begin
			@(negedge ref_clk_i);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			if (bh) rsp = bresp;
			@(posedge ref_clk_i);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask

	task automatic rd_reg(input logic [9:0] a);
		logic ah, rh;
		bit done;
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 0;
		while (!done) begin
			@(negedge ref_clk_i);
			ah = arvalid & arready;
			rh = rvalid & rready;
			if (rh) begin
				rsp = rresp;
				rdv = rdata;
			end
			@(posedge ref_clk_i);
			if (ah) arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask

	task automatic chk_reset;
		rd_reg(ba(dgp_pkg::IDX_PORT_H_DIRECTION));
		chk("h_dir", 32'hff, rdv);
		rd_reg(ba(dgp_pkg::IDX_PORT_J_DIRECTION));
		chk("j_dir", 32'hff, rdv);
		rd_reg(ba(dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE));
		chk("cfg", 32'h00, rdv);
		chk8("h_oe", 8'hff, h_oe);
		chk8("j_oe", 8'hff, j_oe);
		chk8("ana", 8'h0f, {4'h0, ana});
		rd_reg(ba(dgp_pkg::IDX_PORT_J_PINS_LATCH));
		chk("j_pins_in", 32'ha5, rdv);
	endtask

	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		rst_i = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 10'h0;
		araddr = 10'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		h_ext = 8'h5a;
		j_ext = 8'ha5;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk_reset();
		// Latch loaded before direction so new outputs never show stale data
		wr(ba(dgp_pkg::IDX_PORT_J_PINS_LATCH), 8'h3c);
		wr(ba(dgp_pkg::IDX_PORT_J_DIRECTION), 8'h0f);
		repeat (6) @(posedge ref_clk_i);
		chk8("j_oe", 8'h0f, j_oe);
		chk8("j_out", 8'h30, j_o & 8'hf0);
		rd_reg(ba(dgp_pkg::IDX_PORT_J_PINS_LATCH));
		chk("j_pins_mix", 32'h35, rdv);
		for (int i = 0; i < 4; i++) begin
			wr(ba(dgp_pkg::IDX_PORT_J_BIT_OP), {3'h0, opc[i], opb[i]});
			chk8("op_resp", {6'h0, dgp_pkg::AXI_OKAY}, {6'h0, rsp});
			repeat (6) @(posedge ref_clk_i);
			rd_reg(ba(dgp_pkg::IDX_PORT_J_BIT_OP));
			chk("j_latch", {24'h0, ope[i]}, rdv);
			chk8("j_out_op", ope[i] & 8'hf0, j_o & 8'hf0);
		end
		wr(ba(dgp_pkg::IDX_PORT_J_DIRECTION), 8'h00);
		repeat (6) @(posedge ref_clk_i);
		chk8("j_oe_all", 8'h00, j_oe);
		chk8("j_out_all", 8'h95, j_o);
		// Lane zero off: the write is answered but the latch keeps its value
		wstrb <= 4'he;
		wr(ba(dgp_pkg::IDX_PORT_J_PINS_LATCH), 8'h00);
		wstrb <= 4'hf;
		chk8("strb_resp", {6'h0, dgp_pkg::AXI_OKAY}, {6'h0, rsp});
		rd_reg(ba(dgp_pkg::IDX_PORT_J_BIT_OP));
		chk("strb_latch", 32'h95, rdv);
		wr(ba(dgp_pkg::IDX_PORT_H_PINS_LATCH), 8'ha5);
		wr(ba(dgp_pkg::IDX_PORT_H_DIRECTION), 8'h00);
		repeat (6) @(posedge ref_clk_i);
		chk8("h_oe_an", 8'hf0, h_oe);
		chk8("h_out_lo", 8'h05, h_o & 8'h0f);
		for (int i = 0; i < 3; i++) begin
			wr(ba(dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE), cfg[i]);
			repeat (6) @(posedge ref_clk_i);
			chk8("ana_cfg", {4'h0, cfa[i]}, {4'h0, ana});
			chk8("h_oe_cfg", cfo[i], h_oe);
			rd_reg(ba(dgp_pkg::IDX_ANALOG_CONVERTER_CONFIG_ONE));
			chk("cfg_rd", {24'h0, cfr[i]}, rdv);
		end
		rd_reg(ba(dgp_pkg::IDX_PORT_H_PINS_LATCH));
		chk("h_pins", 32'ha5, rdv);
		wr(10'h07c, 8'h11);
		chk8("bad_wr", {6'h0, dgp_pkg::AXI_SLVERR}, {6'h0, rsp});
		rd_reg(10'h07c);
		chk8("bad_rd", {6'h0, dgp_pkg::AXI_SLVERR}, {6'h0, rsp});
		rd_reg(10'h041);
		chk8("unaligned", {6'h0, dgp_pkg::AXI_SLVERR}, {6'h0, rsp});
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk_reset();
		close_out();
	end
endmodule // dgp_top_tb
`default_nettype wire
